// file: hw/mac_exec_params.svh
// register offsets, command width, pointer steps and reset word of the move/ALU executor
`ifndef MAC_EXEC_PARAMS_SVH
`define MAC_EXEC_PARAMS_SVH
`define ADR_CMD 8'h00
`define ADR_STATUS 8'h04
`define ADR_ACC0_LO 8'h08
`define ADR_ACC0_HI 8'h0C
`define ADR_ACC1_LO 8'h10
`define ADR_ACC1_HI 8'h14
`define ADR_X 8'h18
`define ADR_Y 8'h1C
`define ADR_P 8'h20
`define ADR_PTR0 8'h24
`define ADR_PTR1 8'h28
`define ADR_PTR2 8'h2C
`define ADR_PTR3 8'h30
`define ADR_J 8'h34
`define ADR_K 8'h38
`define ADR_TPTR 8'h3C
`define ADR_TSTEP 8'h40
`define ADR_RAM_ADDR 8'h44
`define ADR_RAM_DATA 8'h48
`define CMD_W 15
`define RST_WORD 16'h0000
`define STEP_ONE 16'h0001
`define STEP_TWO 16'h0002
`define STEP_MINUS_ONE 16'hFFFF
`endif

// file: hw/mac_exec_pkg.sv
// types shared by the move/ALU executor and its bench
package mac_exec_pkg;
    typedef enum logic [3:0] {
        OP_MUL_P = 4'h0, OP_ADD_P_MUL = 4'h1, OP_MUL = 4'h2, OP_SUB_P_MUL = 4'h3,
        OP_P = 4'h4, OP_ADD_P = 4'h5, OP_NOP = 4'h6, OP_SUB_P = 4'h7,
        OP_OR_Y = 4'h8, OP_XOR_Y = 4'h9, OP_AND_TEST = 4'hA, OP_SUB_TEST = 4'hB,
        OP_LOAD_Y = 4'hC, OP_ADD_Y = 4'hD, OP_AND_Y = 4'hE, OP_SUB_Y = 4'hF
    } op_t;
    typedef enum logic [2:0] {
        MV_X_LOAD = 3'h0, MV_Y_LOAD = 3'h1, MV_YX_TABLE = 3'h2, MV_ACC_Y_TABLE = 3'h3,
        MV_ACC_LOAD = 3'h4, MV_Y_STORE = 3'h5, MV_Y_SWAP = 3'h6, MV_NONE = 3'h7
    } move_t;
    typedef enum logic [1:0] {ST_IDLE, ST_FIRST, ST_SECOND} state_t;
    typedef struct packed {
        logic cache;
        logic [3:0] sel;
        logic xb;
        logic s;
        logic d;
        move_t move;
        op_t op;
    } cmd_t;
    typedef struct packed {
        logic n;
        logic z;
        logic c;
        logic v;
    } flags_t;
    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [7:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } wb_req_t;
endpackage : mac_exec_pkg

// file: hw/mac_parallel_move_exec.sv
// multiply/ALU executor with parallel data moves, registers on classic Wishbone
//
// The implementer's own choices: the address map and the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none
`include "mac_exec_params.svh"

module mac_parallel_move_exec #(
    parameter int RAM_AW = 9,
    parameter logic [15:0] INT_ROM_LIMIT = 16'h1000
) (
    input wire logic clk_sys, // system clock, 50 MHz
    input wire logic rst_n, // synchronous reset, active low
    input wire mac_exec_pkg::wb_req_t wb_req, // Wishbone request bundle
    output logic wb_ack_o, // Wishbone acknowledge
    output logic [31:0] wb_dat_o, // Wishbone read data
    input wire logic external_rom_select, // pin forcing external ROM
    input wire logic [15:0] rom_data, // ROM word at rom_addr
    output logic [15:0] rom_addr, // ROM address, the table pointer
    output logic rom_ext, // fetch goes to external ROM
    output logic rom_rd, // table fetch this cycle
    output logic busy // instruction in progress
);
    ////////////////////////////////////////////////////////////////////////
    // state
    mac_exec_pkg::state_t state_q, state_d;
    mac_exec_pkg::cmd_t cmd_q, cmd_d;
    mac_exec_pkg::flags_t flags_q, flags_d, dau_flags;
    logic [35:0] acc_q [2];
    logic [35:0] acc_d [2];
    logic [15:0] ptr_q [4];
    logic [15:0] ptr_d [4];
    logic [15:0] x_q, x_d, j_q, j_d, k_q, k_d, tptr_q, tptr_d, tstep_q, tstep_d;
    logic [15:0] temp_q, temp_d, ram_addr_q, ram_addr_d;
    logic [31:0] y_q, y_d, p_q, p_d, rd_val, wdat, dat_q, dat_d, prod;
    logic ack_q, ack_d, ext_s1_q, ext_s2_q;
    logic [15:0] ram_q [2**RAM_AW];
    logic ram_we, tfetch, wr_now, dau_wr, dau_mul, arith, sub;
    logic [RAM_AW-1:0] ram_wa;
    logic [15:0] ram_wd, ram_rdw, step1, step2;
    logic [1:0] psel;
    logic [35:0] as, b, res, y_ext, p_ext;
    logic [36:0] uns;

    ////////////////////////////////////////////////////////////////////////
    // bus slave: one ack per request, byte lanes merge into the old value
    assign ack_d = wb_req.cyc & wb_req.stb & ~ack_q;
    assign wr_now = ack_q & wb_req.cyc & wb_req.stb & wb_req.we; // write lands at the edge ack is sampled
    assign wb_ack_o = ack_q;
    assign wb_dat_o = dat_q;
    assign dat_d = ack_d ? rd_val : dat_q;
    for (genvar g = 0; g < 4; g++)
    begin : g_lane
        assign wdat[8*g+:8] = wb_req.sel[g] ? wb_req.dat[8*g+:8] : rd_val[8*g+:8];
    end

    // read mux, unmapped offsets read as zero
    always_comb
    begin
        case (wb_req.adr)
            `ADR_CMD: rd_val = {17'h0, cmd_q};
            `ADR_STATUS: rd_val = {24'h0, flags_q, 3'h0, busy};
            `ADR_ACC0_LO: rd_val = acc_q[0][31:0];
            `ADR_ACC0_HI: rd_val = {28'h0, acc_q[0][35:32]};
            `ADR_ACC1_LO: rd_val = acc_q[1][31:0];
            `ADR_ACC1_HI: rd_val = {28'h0, acc_q[1][35:32]};
            `ADR_X: rd_val = {16'h0, x_q};
            `ADR_Y: rd_val = y_q;
            `ADR_P: rd_val = p_q;
            `ADR_PTR0: rd_val = {16'h0, ptr_q[0]};
            `ADR_PTR1: rd_val = {16'h0, ptr_q[1]};
            `ADR_PTR2: rd_val = {16'h0, ptr_q[2]};
            `ADR_PTR3: rd_val = {16'h0, ptr_q[3]};
            `ADR_J: rd_val = {16'h0, j_q};
            `ADR_K: rd_val = {16'h0, k_q};
            `ADR_TPTR: rd_val = {16'h0, tptr_q};
            `ADR_TSTEP: rd_val = {16'h0, tstep_q};
            `ADR_RAM_ADDR: rd_val = {16'h0, ram_addr_q};
            `ADR_RAM_DATA: rd_val = {16'h0, ram_q[ram_addr_q[RAM_AW-1:0]]};
            default: rd_val = 32'h0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // arithmetic unit; reads only old register values, so moves see pre-op state
    assign as = acc_q[cmd_q.s];
    assign y_ext = {{4{y_q[31]}}, y_q};
    assign p_ext = {{4{p_q[31]}}, p_q};
    assign prod = $signed(x_q) * $signed(y_q[31:16]);
    assign b = cmd_q.op[3] ? y_ext : p_ext;
    assign sub = &cmd_q.op[1:0];
    assign uns = sub ? {1'b0, as} - {1'b0, b} : {1'b0, as} + {1'b0, b};
    assign dau_mul = ~cmd_q.op[3] & ~cmd_q.op[2];

    // operation decode: result, accumulator write and arithmetic flag
    always_comb
    begin
        res = uns[35:0];
        dau_wr = 1'b1;
        arith = 1'b1;
        unique case (cmd_q.op)
            mac_exec_pkg::OP_MUL_P, mac_exec_pkg::OP_P:
            begin
                res = p_ext;
                arith = 1'b0;
            end
            mac_exec_pkg::OP_MUL:
            begin
                res = {{4{prod[31]}}, prod};
                dau_wr = 1'b0;
                arith = 1'b0;
            end
            mac_exec_pkg::OP_ADD_P_MUL, mac_exec_pkg::OP_SUB_P_MUL, mac_exec_pkg::OP_ADD_P,
            mac_exec_pkg::OP_SUB_P, mac_exec_pkg::OP_ADD_Y, mac_exec_pkg::OP_SUB_Y:
                res = uns[35:0];
            mac_exec_pkg::OP_NOP:
            begin
                res = as;
                dau_wr = 1'b0;
                arith = 1'b0;
            end
            mac_exec_pkg::OP_OR_Y:
            begin
                res = as | b;
                arith = 1'b0;
            end
            mac_exec_pkg::OP_XOR_Y:
            begin
                res = as ^ b;
                arith = 1'b0;
            end
            mac_exec_pkg::OP_AND_TEST:
            begin
                res = as & b;
                dau_wr = 1'b0;
                arith = 1'b0;
            end
            mac_exec_pkg::OP_SUB_TEST:
                dau_wr = 1'b0;
            mac_exec_pkg::OP_LOAD_Y:
            begin
                res = b;
                arith = 1'b0;
            end
            mac_exec_pkg::OP_AND_Y:
            begin
                res = as & b;
                arith = 1'b0;
            end
        endcase
    end

    // flags come from the produced value, carry and overflow only for add/sub
    assign dau_flags.n = res[35];
    assign dau_flags.z = (res == 36'h0_0000_0000);
    assign dau_flags.c = arith & uns[36];
    assign dau_flags.v = arith & (as[35] == (b[35] ^ sub)) & (res[35] != as[35]);

    ////////////////////////////////////////////////////////////////////////
    // pointer select and post-modification amounts
    assign psel = cmd_q.sel[3:2];
    assign ram_rdw = ram_q[ptr_q[psel][RAM_AW-1:0]];
    always_comb
    begin
        step1 = `RST_WORD;
        step2 = `RST_WORD;
        if (cmd_q.move == mac_exec_pkg::MV_Y_SWAP)
        begin
            unique case (cmd_q.sel[1:0])
                2'h0: step2 = `STEP_ONE;
                2'h1: step1 = `STEP_ONE;
                2'h2:
                begin
                    step1 = `STEP_MINUS_ONE;
                    step2 = `STEP_TWO;
                end
                2'h3:
                begin
                    step1 = j_q;
                    step2 = k_q;
                end
            endcase
        end
        else
        begin
            unique case (cmd_q.sel[1:0])
                2'h0: step1 = `RST_WORD;
                2'h1: step1 = `STEP_ONE;
                2'h2: step1 = `STEP_MINUS_ONE;
                2'h3: step1 = j_q;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // sequencer and register next values; software writes are ignored while busy
    always_comb
    begin
        state_d = state_q;
        cmd_d = cmd_q;
        flags_d = flags_q;
        acc_d = acc_q;
        ptr_d = ptr_q;
        x_d = x_q;
        y_d = y_q;
        p_d = p_q;
        j_d = j_q;
        k_d = k_q;
        tptr_d = tptr_q;
        tstep_d = tstep_q;
        temp_d = temp_q;
        ram_addr_d = ram_addr_q;
        ram_we = 1'b0;
        ram_wa = ram_addr_q[RAM_AW-1:0];
        ram_wd = wdat[15:0];
        tfetch = 1'b0;
        if (wr_now && state_q == mac_exec_pkg::ST_IDLE)
        begin
            case (wb_req.adr)
                `ADR_CMD:
                begin
                    cmd_d = mac_exec_pkg::cmd_t'(wdat[`CMD_W-1:0]);
                    state_d = mac_exec_pkg::ST_FIRST;
                end
                `ADR_ACC0_LO: acc_d[0][31:0] = wdat;
                `ADR_ACC0_HI: acc_d[0][35:32] = wdat[3:0];
                `ADR_ACC1_LO: acc_d[1][31:0] = wdat;
                `ADR_ACC1_HI: acc_d[1][35:32] = wdat[3:0];
                `ADR_X: x_d = wdat[15:0];
                `ADR_Y: y_d = wdat;
                `ADR_P: p_d = wdat;
                `ADR_PTR0: ptr_d[0] = wdat[15:0];
                `ADR_PTR1: ptr_d[1] = wdat[15:0];
                `ADR_PTR2: ptr_d[2] = wdat[15:0];
                `ADR_PTR3: ptr_d[3] = wdat[15:0];
                `ADR_J: j_d = wdat[15:0];
                `ADR_K: k_d = wdat[15:0];
                `ADR_TPTR: tptr_d = wdat[15:0];
                `ADR_TSTEP: tstep_d = wdat[15:0];
                `ADR_RAM_ADDR: ram_addr_d = wdat[15:0];
                `ADR_RAM_DATA: ram_we = 1'b1;
                default: ;
            endcase
        end
        unique case (state_q)
            mac_exec_pkg::ST_IDLE: ;
            mac_exec_pkg::ST_FIRST:
            begin
                state_d = mac_exec_pkg::ST_IDLE;
                if (cmd_q.op != mac_exec_pkg::OP_NOP)
                    flags_d = dau_flags;
                if (dau_mul)
                    p_d = prod;
                if (dau_wr)
                    acc_d[cmd_q.d] = res;
                ptr_d[psel] = ptr_q[psel] + step1;
                unique case (cmd_q.move)
                    mac_exec_pkg::MV_X_LOAD: x_d = ram_rdw;
                    mac_exec_pkg::MV_Y_LOAD:
                        y_d = cmd_q.xb ? {ram_rdw, 16'h0} : {y_q[31:16], ram_rdw};
                    mac_exec_pkg::MV_YX_TABLE, mac_exec_pkg::MV_ACC_Y_TABLE:
                    begin
                        if (cmd_q.move == mac_exec_pkg::MV_YX_TABLE)
                            y_d = {ram_rdw, 16'h0};
                        else
                        begin
                            y_d = acc_q[cmd_q.sel[0]][31:0];
                            ptr_d[psel] = ptr_q[psel];
                        end
                        tfetch = cmd_q.cache;
                        if (!cmd_q.cache)
                            state_d = mac_exec_pkg::ST_SECOND;
                    end
                    mac_exec_pkg::MV_ACC_LOAD:
                    begin
                        if (cmd_q.xb)
                            acc_d[!cmd_q.d] = {{4{ram_rdw[15]}}, ram_rdw, 16'h0};
                        else
                            acc_d[!cmd_q.d][15:0] = ram_rdw;
                    end
                    mac_exec_pkg::MV_Y_STORE:
                    begin
                        ram_we = 1'b1;
                        ram_wa = ptr_q[psel][RAM_AW-1:0];
                        ram_wd = cmd_q.xb ? y_q[31:16] : y_q[15:0];
                        state_d = mac_exec_pkg::ST_SECOND;
                    end
                    mac_exec_pkg::MV_Y_SWAP:
                    begin
                        temp_d = cmd_q.xb ? y_q[31:16] : y_q[15:0];
                        y_d = cmd_q.xb ? {ram_rdw, 16'h0} : {y_q[31:16], ram_rdw};
                        state_d = mac_exec_pkg::ST_SECOND;
                    end
                    mac_exec_pkg::MV_NONE: ptr_d[psel] = ptr_q[psel];
                endcase
            end
            mac_exec_pkg::ST_SECOND:
            begin
                state_d = mac_exec_pkg::ST_IDLE;
                if (cmd_q.move == mac_exec_pkg::MV_Y_SWAP)
                begin
                    ram_we = 1'b1;
                    ram_wa = ptr_q[psel][RAM_AW-1:0];
                    ram_wd = temp_q;
                    ptr_d[psel] = ptr_q[psel] + step2;
                end
                tfetch = (cmd_q.move == mac_exec_pkg::MV_YX_TABLE) ||
                         (cmd_q.move == mac_exec_pkg::MV_ACC_Y_TABLE);
            end
            default: state_d = mac_exec_pkg::ST_IDLE;
        endcase
        if (tfetch)
        begin
            x_d = rom_data;
            tptr_d = tptr_q + (cmd_q.xb ? tstep_q : `STEP_ONE);
        end
    end

    // ROM side: the pin is synchronised, an address at or above the limit goes outside
    assign rom_addr = tptr_q;
    assign rom_ext = ext_s2_q | (tptr_q >= INT_ROM_LIMIT);
    assign rom_rd = tfetch;
    assign busy = (state_q != mac_exec_pkg::ST_IDLE);

    ////////////////////////////////////////////////////////////////////////
    // registers; RAM contents have no reset, software must preload them
    always_ff @(posedge clk_sys)
    begin
        if (ram_we)
            ram_q[ram_wa] <= ram_wd;
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            state_q <= mac_exec_pkg::ST_IDLE;
            cmd_q <= '0;
            flags_q <= '0;
            acc_q <= '{default: '0};
            ptr_q <= '{default: '0};
            {x_q, j_q, k_q, tptr_q, tstep_q, temp_q, ram_addr_q} <= '0;
            {y_q, p_q, dat_q} <= '0;
            {ack_q, ext_s1_q, ext_s2_q} <= '0;
        end
        else
        begin
            state_q <= state_d;
            cmd_q <= cmd_d;
            flags_q <= flags_d;
            acc_q <= acc_d;
            ptr_q <= ptr_d;
            {x_q, j_q, k_q, tptr_q, tstep_q, temp_q, ram_addr_q} <=
                {x_d, j_d, k_d, tptr_d, tstep_d, temp_d, ram_addr_d};
            {y_q, p_q, dat_q} <= {y_d, p_d, dat_d};
            {ack_q, ext_s1_q, ext_s2_q} <= {ack_d, external_rom_select, ext_s1_q};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    logic first_plain;
    assign first_plain = (state_q == mac_exec_pkg::ST_FIRST) && cmd_q.move != mac_exec_pkg::MV_Y_SWAP &&
                         cmd_q.move <= mac_exec_pkg::MV_YX_TABLE;

    a_ptr_post_inc: assert property (first_plain && cmd_q.sel[1:0] == 2'h1 |=>
        ptr_q[$past(psel)] == $past(ptr_q[psel]) + 16'h0001) else $error("pointer not incremented");
    a_table_step: assert property (tfetch && cmd_q.xb |=> tptr_q == $past(tptr_q) + $past(tstep_q))
        else $error("table pointer step wrong");
    a_table_cycles: assert property (state_q == mac_exec_pkg::ST_FIRST && cmd_q.move ==
        mac_exec_pkg::MV_YX_TABLE && !cmd_q.cache |=> busy ##1 !busy) else $error("table load not two cycles");
    a_test_keeps_acc: assert property (state_q == mac_exec_pkg::ST_FIRST &&
        cmd_q.op == mac_exec_pkg::OP_AND_TEST && cmd_q.move != mac_exec_pkg::MV_ACC_LOAD |=>
        acc_q[0] == $past(acc_q[0]) && acc_q[1] == $past(acc_q[1])) else $error("test op changed accumulator");
    a_copy_old_acc: assert property (state_q == mac_exec_pkg::ST_FIRST &&
        cmd_q.move == mac_exec_pkg::MV_ACC_Y_TABLE |=> y_q == $past(acc_q[cmd_q.sel[0]][31:0]))
        else $error("y did not get old accumulator");
    a_load_target: assert property (state_q == mac_exec_pkg::ST_FIRST &&
        cmd_q.move == mac_exec_pkg::MV_ACC_LOAD && cmd_q.xb |=>
        acc_q[!cmd_q.d][31:16] == $past(ram_rdw) && !busy) else $error("accumulator load wrong");
    a_store_two: assert property ($rose(busy) && cmd_q.move == mac_exec_pkg::MV_Y_STORE |->
        busy [*2] ##1 !busy) else $error("store not two cycles");
    a_swap_second: assert property (state_q == mac_exec_pkg::ST_SECOND &&
        cmd_q.move == mac_exec_pkg::MV_Y_SWAP && cmd_q.sel[1:0] == 2'h2 |=>
        ptr_q[cmd_q.sel[3:2]] == $past(ptr_q[psel]) + 16'h0002) else $error("second modification wrong");
    a_sign_extend: assert property (state_q == mac_exec_pkg::ST_FIRST &&
        cmd_q.op == mac_exec_pkg::OP_LOAD_Y |=> acc_q[cmd_q.d] == {{4{$past(y_q[31])}}, $past(y_q)})
        else $error("y not sign extended");
    c_swap: cover property (state_q == mac_exec_pkg::ST_SECOND && cmd_q.move == mac_exec_pkg::MV_Y_SWAP);
    c_cached_table: cover property (tfetch && state_q == mac_exec_pkg::ST_FIRST);
    c_acc_load: cover property (state_q == mac_exec_pkg::ST_FIRST && cmd_q.move == mac_exec_pkg::MV_ACC_LOAD);
endmodule : mac_parallel_move_exec
`default_nettype wire

// file: verif/mac_parallel_move_exec_tb.sv
// self-checking bench for the move/alu executor
`timescale 1ns/1ps
`default_nettype none
`include "mac_exec_params.svh"
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin fails++; \
    $display("Error %s expected %h seen %h", nm, e, g); end end
module mac_parallel_move_exec_tb;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    mac_exec_pkg::wb_req_t req = '0;
    logic ack, rom_ext, rom_rd, busy;
    logic [31:0] rdat;
    logic ext_sel = 1'b0;
    logic [15:0] rom_data, rom_addr, tp;
    logic [31:0] yexp;
    int fails = 0;
    int checked = 0;
    int busy_cycles = 0;
    int pm[4] = '{0, 1, -1, 3};
    int first[4] = '{0, 1, -1, 3};
    int second[4] = '{1, 0, 2, 5};
    ////////////////////////////////////////////////////////////////////
    // clock and a count of cycles spent busy, sampled at each rising edge
    always #10 clk_sys = ~clk_sys;
    always @(posedge clk_sys) if (busy === 1'b1) busy_cycles <= busy_cycles + 1;
    mac_parallel_move_exec u_dut (.clk_sys(clk_sys), .rst_n(rst_n), .wb_req(req), .wb_ack_o(ack),
        .wb_dat_o(rdat), .external_rom_select(ext_sel), .rom_data(rom_data), .rom_addr(rom_addr),
        .rom_ext(rom_ext), .rom_rd(rom_rd), .busy(busy));
    rom_model u_rom (.rom_addr(rom_addr), .rom_ext(rom_ext), .rom_rd(rom_rd), .rom_data(rom_data));
    ////////////////////////////////////////////////////////////////////
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : give_verdict
    // one classic cycle: hold everything until ack is sampled, then release
    task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk_sys);
        req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: 4'hF, dat: d};
        do
        begin
            @(posedge clk_sys);
            n++;
        end
        while (ack !== 1'b1 && n < 50);
        q = rdat;
        req <= '0;
        if (ack !== 1'b1)
        begin
            fails++;
            give_verdict();
        end
    endtask : bus
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask : wr
    task automatic rc(input logic [7:0] a, input logic [31:0] e, input string nm);
        logic [31:0] q;
        bus(1'b0, a, 32'h0000_0000, q);
        `CHK(nm, e, q)
    endtask : rc
    function automatic logic [14:0] mk(mac_exec_pkg::op_t op, mac_exec_pkg::move_t mv, logic d,
        logic s, logic xb, logic [3:0] sel, logic cache);
        mac_exec_pkg::cmd_t c;
        c = '{cache: cache, sel: sel, xb: xb, s: s, d: d, move: mv, op: op};
        return c;
    endfunction : mk
    // issue an instruction in idle and count how long busy stands
    task automatic exec(input logic [14:0] c, input int cyc_exp);
        int b0, n;
        b0 = busy_cycles;
        wr(`ADR_CMD, {17'h0_0000, c});
        // the command lands at the ack edge, so busy shows one edge later
        @(posedge clk_sys);
        n = 0;
        while (busy === 1'b1 && n < 20)
        begin
            @(posedge clk_sys);
            n++;
        end
        if (busy === 1'b1)
        begin
            fails++;
            give_verdict();
        end
        @(posedge clk_sys);
        `CHK("busy cycles", cyc_exp, busy_cycles - b0)
    endtask : exec
    // watchdog: a hang ends in the same verdict
    initial
    begin
        repeat (20000) @(posedge clk_sys);
        fails++;
        give_verdict();
    end
    ////////////////////////////////////////////////////////////////////
    // main sequence
    initial
    begin
        repeat (6) @(posedge clk_sys);
        rst_n <= 1'b1;
        rc(`ADR_STATUS, 32'h0000_0000, "status reset");
        rc(8'hFC, 32'h0000_0000, "unmapped read");
        wr(`ADR_J, 32'h0000_0003);
        wr(`ADR_K, 32'h0000_0005);
        $display("test reset done");
        // each pointer with its own modify code, whole and low-half loads
        yexp = 32'h0000_0000;
        for (int i = 0; i < 4; i++)
        begin
            wr(`ADR_PTR0 + 8'(4 * i), 32'h0000_0020);
            wr(`ADR_RAM_ADDR, 32'h0000_0020);
            wr(`ADR_RAM_DATA, 32'(16'h1234 + i));
            exec(mk(mac_exec_pkg::OP_NOP, mac_exec_pkg::MV_Y_LOAD, 1'b0, 1'b0, i[0], 4'(i * 5), 1'b0), 1);
            if (i[0]) yexp = {16'(16'h1234 + i), 16'h0000};
            else yexp[15:0] = 16'(16'h1234 + i);
            rc(`ADR_Y, yexp, "y load");
            rc(`ADR_PTR0 + 8'(4 * i), 32'(32 + pm[i]), "ptr modify");
        end
        $display("test y load done");
        // table fetch: step select, rom choice by pin, cached timing
        wr(`ADR_TSTEP, 32'h0000_0010);
        wr(`ADR_TPTR, 32'h0000_0100);
        tp = 16'h0100;
        for (int i = 0; i < 4; i++)
        begin
            ext_sel <= i[1];
            repeat (3) @(posedge clk_sys);
            exec(mk(mac_exec_pkg::OP_NOP, mac_exec_pkg::MV_YX_TABLE, 1'b0, 1'b0, i[0], 4'h0, i[1]), 2 - i[1]);
            rc(`ADR_X, 32'(tp ^ (i[1] ? 16'hA5A5 : 16'h5A5A)), "x table");
            tp = tp + (i[0] ? 16'h0010 : 16'h0001);
            rc(`ADR_TPTR, 32'(tp), "table step");
        end
        ext_sel <= 1'b0;
        // pin low again, but an address at the limit still goes outside
        wr(`ADR_TPTR, 32'h0000_1000);
        exec(mk(mac_exec_pkg::OP_NOP, mac_exec_pkg::MV_YX_TABLE, 1'b0, 1'b0, 1'b0, 4'h0, 1'b1), 1);
        rc(`ADR_X, 32'h0000_B5A5, "x rom by address");
        $display("test table done");
        // operations with y sign-extended, flags and test-only codes
        wr(`ADR_Y, 32'h8001_0002);
        exec(mk(mac_exec_pkg::OP_LOAD_Y, mac_exec_pkg::MV_NONE, 1'b1, 1'b0, 1'b0, 4'h0, 1'b0), 1);
        rc(`ADR_ACC1_HI, 32'h0000_000F, "load y high");
        exec(mk(mac_exec_pkg::OP_AND_TEST, mac_exec_pkg::MV_NONE, 1'b1, 1'b0, 1'b0, 4'h0, 1'b0), 1);
        rc(`ADR_STATUS, 32'h0000_0040, "and test flags");
        rc(`ADR_ACC1_LO, 32'h8001_0002, "and test keeps");
        exec(mk(mac_exec_pkg::OP_ADD_Y, mac_exec_pkg::MV_NONE, 1'b0, 1'b1, 1'b0, 4'h0, 1'b0), 1);
        rc(`ADR_ACC0_LO, 32'h0002_0004, "add y");
        rc(`ADR_STATUS, 32'h0000_00A0, "add flags");
        exec(mk(mac_exec_pkg::OP_XOR_Y, mac_exec_pkg::MV_NONE, 1'b0, 1'b0, 1'b0, 4'h0, 1'b0), 1);
        rc(`ADR_ACC0_HI, 32'h0000_0000, "xor y high");
        rc(`ADR_STATUS, 32'h0000_0000, "xor flags");
        wr(`ADR_X, 32'h0000_0003);
        exec(mk(mac_exec_pkg::OP_MUL, mac_exec_pkg::MV_NONE, 1'b0, 1'b0, 1'b0, 4'h0, 1'b0), 1);
        rc(`ADR_P, 32'hFFFE_8003, "product");
        rc(`ADR_STATUS, 32'h0000_0080, "mul flags");
        exec(mk(mac_exec_pkg::OP_P, mac_exec_pkg::MV_NONE, 1'b1, 1'b0, 1'b0, 4'h0, 1'b0), 1);
        rc(`ADR_ACC1_LO, 32'hFFFE_8003, "acc from p");
        // copy into y sees the accumulator from before the operation
        exec(mk(mac_exec_pkg::OP_ADD_Y, mac_exec_pkg::MV_ACC_Y_TABLE, 1'b0, 1'b0, 1'b0, 4'h0, 1'b0), 2);
        rc(`ADR_Y, 32'h8003_0006, "y old acc");
        rc(`ADR_ACC0_LO, 32'h0004_0008, "op old y");
        $display("test ops done");
        // accumulator load: d low loads the second, op goes to the first
        wr(`ADR_PTR1, 32'h0000_0040);
        wr(`ADR_RAM_ADDR, 32'h0000_0040);
        wr(`ADR_RAM_DATA, 32'h0000_9000);
        exec(mk(mac_exec_pkg::OP_LOAD_Y, mac_exec_pkg::MV_ACC_LOAD, 1'b0, 1'b0, 1'b1, 4'h5, 1'b0), 1);
        rc(`ADR_ACC1_LO, 32'h9000_0000, "acc load");
        rc(`ADR_ACC0_LO, 32'h8003_0006, "op other acc");
        rc(`ADR_PTR1, 32'h0000_0041, "acc load ptr");
        // y store, high half then low half
        wr(`ADR_Y, 32'h4321_8765);
        wr(`ADR_PTR2, 32'h0000_0050);
        for (int i = 0; i < 2; i++)
        begin
            exec(mk(mac_exec_pkg::OP_NOP, mac_exec_pkg::MV_Y_STORE, 1'b0, 1'b0, ~i[0], 4'hA, 1'b0), 2);
            wr(`ADR_RAM_ADDR, 32'(32'h50 - i));
            rc(`ADR_RAM_DATA, i ? 32'h0000_8765 : 32'h0000_4321, "y store");
        end
        // compound swap for every modify pair, pointer from the high bits
        for (int i = 0; i < 4; i++)
        begin
            wr(`ADR_PTR0 + 8'(4 * i), 32'h0000_0060);
            wr(`ADR_RAM_ADDR, 32'h0000_0060);
            wr(`ADR_RAM_DATA, 32'(16'hC000 + i));
            wr(`ADR_Y, 32'h0ABC_0000);
            exec(mk(mac_exec_pkg::OP_NOP, mac_exec_pkg::MV_Y_SWAP, 1'b0, 1'b0, 1'b1, 4'(i * 5), 1'b0), 2);
            rc(`ADR_Y, {16'(16'hC000 + i), 16'h0000}, "swap y");
            wr(`ADR_RAM_ADDR, 32'(32'h60 + first[i]));
            rc(`ADR_RAM_DATA, 32'h0000_0ABC, "swap ram");
            rc(`ADR_PTR0 + 8'(4 * i), 32'(32'h60 + first[i] + second[i]), "swap ptr");
        end
        $display("test moves done");
        give_verdict();
    end
endmodule : mac_parallel_move_exec_tb
`default_nettype wire

// file: verif/rom_model.sv
// behavioural table rom on the far side of the fetch port
`timescale 1ns/1ps
`default_nettype none
module rom_model (
    input wire logic [15:0] rom_addr, // word address, the table pointer
    input wire logic rom_ext, // external rom chosen
    input wire logic rom_rd, // fetch strobe
    output logic [15:0] rom_data // word returned
);
    logic [15:0] word;
    // internal and external contents differ so a wrong choice shows in x
    assign word = rom_addr ^ (rom_ext ? 16'hA5A5 : 16'h5A5A);
    // outside a fetch the bus shows the inverse, never a stale good word
    assign rom_data = rom_rd ? word : ~word;
endmodule : rom_model
`default_nettype wire
